/* File: src/psa_alu_top.sv */
// Packed SIMD integer unit: issue stage, lane datapath, tag word
`timescale 1ns/1ps
module psa_alu_top (
  input wire logic core_clk,
  input wire logic reset,
  input psa_pkg::psa_issue_s issue,
  output psa_pkg::psa_result_s result_r,
  output logic [15:0] tagWord_r,
  input wire logic fpWrEn,
  input wire logic [2:0] fpIdx,
  input wire logic [63:0] fpWrData,
  output logic [63:0] fpRdData
);
  psa_pkg::psa_issue_s stage_r, stage_nxt;
  psa_pkg::psa_fwd_s lastWr_r, lastWr_nxt;
  psa_pkg::psa_result_s result_nxt;
  logic [15:0] tagWord_nxt;
  logic [63:0] rdA, rdB, opA, opB, res;
  logic wrDest, isOut, isSub;
  logic [63:0] wrapB, wrapW, wrapD, satSB, satSW, satUB, satUW;
  logic [63:0] cmpB, cmpW, cmpD, sllW, sllD, srlW, srlD, sraW, sraD;
  logic [63:0] packSB, packSW, packUB, unpLB, unpLW, unpHB, unpHW, madd;
  logic [31:0] mulP [4];
  logic signed [33:0] sA, sB, uA, uB, sumS, sumU;
  logic [15:0] tS, tU;

  // Clamp to the signed byte or word range
  function automatic logic [15:0] satS(input logic signed [33:0] v, input logic isByte);
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    logic signed [33:0] c;
    hi = isByte ? psa_pkg::S8_MAX : psa_pkg::S16_MAX;
    lo = isByte ? psa_pkg::S8_MIN : psa_pkg::S16_MIN;
    c = (v > hi) ? hi : ((v < lo) ? lo : v);
    return c[15:0];
  endfunction

  // Clamp to the unsigned byte or word range
  function automatic logic [15:0] satU(input logic signed [33:0] v, input logic isByte);
    logic signed [33:0] hi;
    logic signed [33:0] c;
    hi = isByte ? psa_pkg::U8_MAX : psa_pkg::U16_MAX;
    c = (v > hi) ? hi : ((v < psa_pkg::U_MIN) ? psa_pkg::U_MIN : v);
    return c[15:0];
  endfunction

  psa_regfile #(
    .WIDTH(psa_pkg::DATA_W),
    .DEPTH(psa_pkg::REG_CNT),
    .IDX_W(psa_pkg::IDX_W)
  ) u_regs (
    .core_clk(core_clk),
    .reset(reset),
    .rdIdxA(issue.dstIdx),
    .rdIdxB(issue.srcIdx),
    .rdDataA(rdA),
    .rdDataB(rdB),
    .wrEn(stage_r.valid && wrDest),
    .wrIdx(stage_r.dstIdx),
    .wrData(res),
    .fpWrEn(fpWrEn),
    .fpIdx(fpIdx),
    .fpWrData(fpWrData),
    .fpRdData(fpRdData)
  );

  // Operand fetch with bypass of the write still landing
  always_comb begin
    opA = rdA;
    opB = rdB;
    if (lastWr_r.valid && lastWr_r.idx == stage_r.dstIdx) begin
      opA = lastWr_r.data;
    end
    if (lastWr_r.valid && lastWr_r.idx == stage_r.srcIdx) begin
      opB = lastWr_r.data;
    end
    if (stage_r.srcExt) begin
      opB = stage_r.extData;
    end
  end

  assign isSub = (stage_r.op == psa_pkg::OP_SUB) || (stage_r.op == psa_pkg::OP_SUBS) ||
                 (stage_r.op == psa_pkg::OP_SUBUS);

  // Byte lanes
  always_comb begin
    {wrapB, satSB, satUB, cmpB, packSB, packUB, unpLB, unpHB} = '0;
    {sA, sB, uA, uB, sumS, sumU, tS, tU} = '0;
    for (int i = 0; i < 8; i++) begin
      // carry out of the lane dropped
      wrapB[i*8+:8] = isSub ? opA[i*8+:8] - opB[i*8+:8] : opA[i*8+:8] + opB[i*8+:8];
      sA = 34'($signed(opA[i*8+:8]));
      sB = 34'($signed(opB[i*8+:8]));
      uA = 34'(opA[i*8+:8]);
      uB = 34'(opB[i*8+:8]);
      sumS = isSub ? sA - sB : sA + sB;
      sumU = isSub ? uA - uB : uA + uB;
      tS = satS(sumS, 1'b1);
      tU = satU(sumU, 1'b1);
      satSB[i*8+:8] = tS[7:0];
      satUB[i*8+:8] = tU[7:0];
      if (stage_r.op == psa_pkg::OP_CMPEQ) begin
        cmpB[i*8+:8] = {8{opA[i*8+:8] == opB[i*8+:8]}};
      end else begin
        cmpB[i*8+:8] = {8{$signed(opA[i*8+:8]) > $signed(opB[i*8+:8])}};
      end
    end
    for (int i = 0; i < 4; i++) begin
      tS = satS(34'($signed(opA[i*16+:16])), 1'b1);
      packSB[i*8+:8] = tS[7:0];
      tS = satS(34'($signed(opB[i*16+:16])), 1'b1);
      packSB[(i+4)*8+:8] = tS[7:0];
      tU = satU(34'($signed(opA[i*16+:16])), 1'b1);
      packUB[i*8+:8] = tU[7:0];
      tU = satU(34'($signed(opB[i*16+:16])), 1'b1);
      packUB[(i+4)*8+:8] = tU[7:0];
      unpLB[i*16+:16] = {opB[i*8+:8], opA[i*8+:8]};
      unpHB[i*16+:16] = {opB[(i+4)*8+:8], opA[(i+4)*8+:8]};
    end
  end

  // Word lanes
  always_comb begin
    {wrapW, satSW, satUW, cmpW, sllW, srlW, sraW} = '0;
    mulP = '{default: '0};
    for (int i = 0; i < 4; i++) begin
      wrapW[i*16+:16] = isSub ? opA[i*16+:16] - opB[i*16+:16] : opA[i*16+:16] + opB[i*16+:16];
      satSW[i*16+:16] = satS(isSub ? 34'($signed(opA[i*16+:16])) - 34'($signed(opB[i*16+:16]))
                                   : 34'($signed(opA[i*16+:16])) + 34'($signed(opB[i*16+:16])), 1'b0);
      satUW[i*16+:16] = satU(isSub ? 34'(opA[i*16+:16]) - 34'(opB[i*16+:16])
                                   : 34'(opA[i*16+:16]) + 34'(opB[i*16+:16]), 1'b0);
      mulP[i] = 32'($signed(opA[i*16+:16])) * 32'($signed(opB[i*16+:16]));
      if (stage_r.op == psa_pkg::OP_CMPEQ) begin
        cmpW[i*16+:16] = {16{opA[i*16+:16] == opB[i*16+:16]}};
      end else begin
        cmpW[i*16+:16] = {16{$signed(opA[i*16+:16]) > $signed(opB[i*16+:16])}};
      end
      sllW[i*16+:16] = (opB > psa_pkg::W_SHIFT_MAX) ? 16'h0000 : opA[i*16+:16] << opB[3:0];
      srlW[i*16+:16] = (opB > psa_pkg::W_SHIFT_MAX) ? 16'h0000 : opA[i*16+:16] >> opB[3:0];
      sraW[i*16+:16] = $signed(opA[i*16+:16]) >>> ((opB > psa_pkg::W_SHIFT_MAX) ? 4'hF : opB[3:0]);
    end
  end

  // Doubleword lanes
  always_comb begin
    {wrapD, cmpD, sllD, srlD, sraD, madd, packSW, unpLW, unpHW} = '0;
    for (int j = 0; j < 2; j++) begin
      wrapD[j*32+:32] = isSub ? opA[j*32+:32] - opB[j*32+:32] : opA[j*32+:32] + opB[j*32+:32];
      if (stage_r.op == psa_pkg::OP_CMPEQ) begin
        cmpD[j*32+:32] = {32{opA[j*32+:32] == opB[j*32+:32]}};
      end else begin
        cmpD[j*32+:32] = {32{$signed(opA[j*32+:32]) > $signed(opB[j*32+:32])}};
      end
      sllD[j*32+:32] = (opB > psa_pkg::D_SHIFT_MAX) ? 32'h0000_0000 : opA[j*32+:32] << opB[4:0];
      srlD[j*32+:32] = (opB > psa_pkg::D_SHIFT_MAX) ? 32'h0000_0000 : opA[j*32+:32] >> opB[4:0];
      sraD[j*32+:32] = $signed(opA[j*32+:32]) >>> ((opB > psa_pkg::D_SHIFT_MAX) ? 5'h1F : opB[4:0]);
      madd[j*32+:32] = mulP[2*j] + mulP[2*j+1];
      packSW[j*16+:16] = satS(34'($signed(opA[j*32+:32])), 1'b0);
      packSW[(j+2)*16+:16] = satS(34'($signed(opB[j*32+:32])), 1'b0);
      unpLW[j*32+:32] = {opB[j*16+:16], opA[j*16+:16]};
      unpHW[j*32+:32] = {opB[(j+2)*16+:16], opA[(j+2)*16+:16]};
    end
  end

  // Operation select; unsupported sizes fall back to a fixed legal one per operation
  always_comb begin
    res = opA;
    wrDest = 1'b1;
    isOut = 1'b0;
    // element view set by the operation and the size field
    case (stage_r.op)
      psa_pkg::OP_ADD, psa_pkg::OP_SUB: begin
        res = (stage_r.size == psa_pkg::SZ_BYTE) ? wrapB : (stage_r.size == psa_pkg::SZ_WORD) ? wrapW : wrapD;
      end
      psa_pkg::OP_ADDS, psa_pkg::OP_SUBS: begin
        res = (stage_r.size == psa_pkg::SZ_BYTE) ? satSB : satSW;
      end
      psa_pkg::OP_ADDUS, psa_pkg::OP_SUBUS: begin
        res = (stage_r.size == psa_pkg::SZ_BYTE) ? satUB : satUW;
      end
      psa_pkg::OP_MULH: begin
        res = {mulP[3][31:16], mulP[2][31:16], mulP[1][31:16], mulP[0][31:16]};
      end
      psa_pkg::OP_MULL: begin
        res = {mulP[3][15:0], mulP[2][15:0], mulP[1][15:0], mulP[0][15:0]};
      end
      psa_pkg::OP_MADD: begin
        res = madd;
      end
      psa_pkg::OP_CMPEQ, psa_pkg::OP_CMPGT: begin
        res = (stage_r.size == psa_pkg::SZ_BYTE) ? cmpB : (stage_r.size == psa_pkg::SZ_WORD) ? cmpW : cmpD;
      end
      psa_pkg::OP_NARROW_SAT_SIGNED: begin
        res = (stage_r.size == psa_pkg::SZ_WORD) ? packSB : packSW;
      end
      psa_pkg::OP_NARROW_SAT_UNSIGNED: begin
        res = packUB;
      end
      psa_pkg::OP_UNPH: begin
        res = (stage_r.size == psa_pkg::SZ_BYTE) ? unpHB : (stage_r.size == psa_pkg::SZ_WORD) ? unpHW
              : {opB[63:32], opA[63:32]};
      end
      psa_pkg::OP_UNPL: begin
        res = (stage_r.size == psa_pkg::SZ_BYTE) ? unpLB : (stage_r.size == psa_pkg::SZ_WORD) ? unpLW
              : {opB[31:0], opA[31:0]};
      end
      psa_pkg::OP_AND: begin
        res = opA & opB;
      end
      psa_pkg::OP_ANDN: begin
        res = ~opA & opB;
      end
      psa_pkg::OP_OR: begin
        res = opA | opB;
      end
      psa_pkg::OP_XOR: begin
        res = opA ^ opB;
      end
      psa_pkg::OP_SLL: begin
        res = (stage_r.size == psa_pkg::SZ_WORD) ? sllW : (stage_r.size == psa_pkg::SZ_DWORD) ? sllD
              : ((opB > psa_pkg::Q_SHIFT_MAX) ? 64'h0000_0000_0000_0000 : opA << opB[5:0]);
      end
      psa_pkg::OP_SRL: begin
        res = (stage_r.size == psa_pkg::SZ_WORD) ? srlW : (stage_r.size == psa_pkg::SZ_DWORD) ? srlD
              : ((opB > psa_pkg::Q_SHIFT_MAX) ? 64'h0000_0000_0000_0000 : opA >> opB[5:0]);
      end
      psa_pkg::OP_SRA: begin
        res = (stage_r.size == psa_pkg::SZ_DWORD) ? sraD : sraW;
      end
      psa_pkg::OP_MOV32_IN: begin
        res = {32'h0000_0000, stage_r.extData[31:0]};
      end
      psa_pkg::OP_MOV32_OUT: begin
        res = {32'h0000_0000, opA[31:0]};
        wrDest = 1'b0;
        isOut = 1'b1;
      end
      // 64 bits in, out or register to register
      psa_pkg::OP_MOV64_IN: begin
        res = stage_r.extData;
      end
      psa_pkg::OP_MOV64_OUT: begin
        res = opA;
        wrDest = 1'b0;
        isOut = 1'b1;
      end
      psa_pkg::OP_MOV64_RR: begin
        res = opB;
      end
      psa_pkg::OP_CLEAR: begin
        res = 64'h0000_0000_0000_0000;
        wrDest = 1'b0;
      end
      default: begin
        wrDest = 1'b0;
      end
    endcase
  end

  // no overflow flag exists to update
  always_comb begin
    stage_nxt = issue;
    lastWr_nxt.valid = stage_r.valid && wrDest;
    lastWr_nxt.idx = stage_r.dstIdx;
    lastWr_nxt.data = res;
    result_nxt.valid = stage_r.valid;
    result_nxt.dstWritten = stage_r.valid && wrDest;
    result_nxt.dstIdx = stage_r.dstIdx;
    result_nxt.extValid = stage_r.valid && isOut;
    result_nxt.data = res;
    tagWord_nxt = tagWord_r;
    if (stage_r.valid) begin
      tagWord_nxt = (stage_r.op == psa_pkg::OP_CLEAR) ? psa_pkg::TAG_EMPTY : psa_pkg::TAG_VALID;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage_r <= '0;
      lastWr_r <= '0;
      result_r <= '0;
      tagWord_r <= psa_pkg::TAG_RESET;
    end else begin
      stage_r <= stage_nxt;
      lastWr_r <= lastWr_nxt;
      result_r <= result_nxt;
      tagWord_r <= tagWord_nxt;
    end
  end

  // Checks on the datapath
  logic [7:0] hWrap0;
  logic signed [8:0] hSumS0;
  logic [15:0] hMulHi0;
  logic [31:0] hMadd0;
  assign hWrap0 = opA[7:0] + opB[7:0];
  assign hSumS0 = $signed({opA[7], opA[7:0]}) + $signed({opB[7], opB[7:0]});
  assign hMulHi0 = mulP[0][31:16];
  assign hMadd0 = mulP[0] + mulP[1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence seqOp(psa_pkg::psa_op_e o, psa_pkg::psa_size_e s);
    stage_r.valid && stage_r.op == o && stage_r.size == s;
  endsequence
  sequence seqPacked;
    stage_r.valid && stage_r.op != psa_pkg::OP_CLEAR;
  endsequence
  sequence seqClear;
    stage_r.valid && stage_r.op == psa_pkg::OP_CLEAR;
  endsequence

  AST_WRAP_BYTE: assert property (seqOp(psa_pkg::OP_ADD, psa_pkg::SZ_BYTE)
    |=> result_r.data[7:0] == $past(hWrap0))
    else $error("wrap byte add wrong");
  AST_SAT_S_HI: assert property (seqOp(psa_pkg::OP_ADDS, psa_pkg::SZ_BYTE) ##0 (hSumS0 > 9'sh07F)
    |=> result_r.data[7:0] == 8'h7F)
    else $error("signed byte not clamped high");
  AST_SAT_S_LO: assert property (seqOp(psa_pkg::OP_ADDS, psa_pkg::SZ_BYTE) ##0 (hSumS0 < -9'sh080)
    |=> result_r.data[7:0] == 8'h80)
    else $error("signed byte not clamped low");
  AST_SAT_U_FLOOR: assert property (seqOp(psa_pkg::OP_SUBUS, psa_pkg::SZ_BYTE) ##0 (opB[7:0] > opA[7:0])
    |=> result_r.data[7:0] == 8'h00)
    else $error("unsigned byte not floored");
  AST_MUL_HIGH: assert property (stage_r.valid && stage_r.op == psa_pkg::OP_MULH
    |=> result_r.data[15:0] == $past(hMulHi0))
    else $error("high product half wrong");
  AST_MADD_PAIR: assert property (stage_r.valid && stage_r.op == psa_pkg::OP_MADD
    |=> result_r.data[31:0] == $past(hMadd0))
    else $error("multiply-add pair sum wrong");
  AST_CMP_MASK: assert property (seqOp(psa_pkg::OP_CMPEQ, psa_pkg::SZ_BYTE) ##0 (opA[7:0] == opB[7:0])
    |=> result_r.data[7:0] == 8'hFF)
    else $error("equal mask not all ones");
  AST_SHIFT_CLEAR: assert property (seqOp(psa_pkg::OP_SRL, psa_pkg::SZ_WORD) ##0 (opB > psa_pkg::W_SHIFT_MAX)
    |=> result_r.data == 64'h0000_0000_0000_0000)
    else $error("oversized shift not zero");
  AST_TAG_VALID: assert property (seqPacked |=> tagWord_r == psa_pkg::TAG_VALID)
    else $error("tag word not valid after packed op");
  AST_TAG_EMPTY: assert property (seqClear |=> tagWord_r == psa_pkg::TAG_EMPTY && !result_r.dstWritten)
    else $error("clear did not empty tag word");
  AST_LATENCY: assert property (issue.valid
    |-> ##2 result_r.valid && result_r.dstIdx == $past(issue.dstIdx, 2))
    else $error("result not two cycles after issue");
endmodule

/* File: src/psa_pkg.sv */
// Constants, enums and structs of the packed SIMD integer unit
// Notes on behaviour
// - Eight 64-bit registers, storage shared with FP state
// - Element size picked by the operation and the size field
// - Wraparound keeps low bits, carry dropped
// - Signed saturation clamps bytes and words
// - Unsigned saturation clamps bytes and words, floor zero
// - No flag or exception on overflow
// - Wrap add and subtract, byte word dword
// - Signed saturating add and subtract, byte word
// - Unsigned saturating add and subtract, byte word
// - Four signed word products, keep high or low
// - Multiply-add sums adjacent products into dwords
// - Compares write all-ones or all-zeros masks
// - Signed pack narrows words or dwords with clamping
// - Unsigned pack narrows signed words to bytes
// - Unpack interleaves upper or lower operand halves
// - AND, AND-NOT, OR, XOR over 64 bits
// - Logical shifts of word, dword, quadword, zero fill
// - Arithmetic right shift of words and dwords
// - 32-bit moves with memory or integer registers
// - 64-bit moves with memory or between registers
// - Destination becomes destination op source
// - Clear operation empties the tag word, no operands
// - Packed ops set tags valid, clear sets empty
package psa_pkg;
  localparam int DATA_W = 64;
  localparam int REG_CNT = 8;
  localparam int IDX_W = 3;
  localparam int TAG_W = 16;
  localparam logic [15:0] TAG_VALID = 16'h0000;
  localparam logic [15:0] TAG_EMPTY = 16'hFFFF;
  localparam logic [15:0] TAG_RESET = 16'hFFFF;
  localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
  localparam logic signed [33:0] S8_MAX = 34'sh0_0000_007F;
  localparam logic signed [33:0] S8_MIN = 34'sh3_FFFF_FF80;
  localparam logic signed [33:0] S16_MAX = 34'sh0_0000_7FFF;
  localparam logic signed [33:0] S16_MIN = 34'sh3_FFFF_8000;
  localparam logic signed [33:0] U8_MAX = 34'sh0_0000_00FF;
  localparam logic signed [33:0] U16_MAX = 34'sh0_0000_FFFF;
  localparam logic signed [33:0] U_MIN = 34'sh0_0000_0000;
  localparam logic [63:0] W_SHIFT_MAX = 64'h0000_0000_0000_000F;
  localparam logic [63:0] D_SHIFT_MAX = 64'h0000_0000_0000_001F;
  localparam logic [63:0] Q_SHIFT_MAX = 64'h0000_0000_0000_003F;
  localparam int LATENCY = 2;

  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_SUB = 5'h01, OP_ADDS = 5'h02, OP_SUBS = 5'h03,
    OP_ADDUS = 5'h04, OP_SUBUS = 5'h05, OP_MULH = 5'h06, OP_MULL = 5'h07,
    OP_MADD = 5'h08, OP_CMPEQ = 5'h09, OP_CMPGT = 5'h0A, OP_NARROW_SAT_SIGNED = 5'h0B,
    OP_NARROW_SAT_UNSIGNED = 5'h0C, OP_UNPH = 5'h0D, OP_UNPL = 5'h0E, OP_AND = 5'h0F,
    OP_ANDN = 5'h10, OP_OR = 5'h11, OP_XOR = 5'h12, OP_SLL = 5'h13,
    OP_SRL = 5'h14, OP_SRA = 5'h15, OP_MOV32_IN = 5'h16, OP_MOV32_OUT = 5'h17,
    OP_MOV64_IN = 5'h18, OP_MOV64_OUT = 5'h19, OP_MOV64_RR = 5'h1A, OP_CLEAR = 5'h1B
  } psa_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2, SZ_QWORD = 2'h3
  } psa_size_e;

  typedef struct packed {
    logic valid;
    psa_op_e op;
    psa_size_e size;
    logic [2:0] dstIdx;
    logic [2:0] srcIdx;
    logic srcExt;
    logic [63:0] extData;
  } psa_issue_s;

  typedef struct packed {
    logic valid;
    logic dstWritten;
    logic [2:0] dstIdx;
    logic extValid;
    logic [63:0] data;
  } psa_result_s;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    logic [63:0] data;
  } psa_fwd_s;
endpackage

/* File: src/psa_regfile.sv */
// Packed register file, shared with the floating-point register view
`timescale 1ns/1ps
module psa_regfile #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8,
  parameter int IDX_W = 3
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [IDX_W-1:0] rdIdxA,
  input wire logic [IDX_W-1:0] rdIdxB,
  output logic [WIDTH-1:0] rdDataA,
  output logic [WIDTH-1:0] rdDataB,
  input wire logic wrEn,
  input wire logic [IDX_W-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic fpWrEn,
  input wire logic [IDX_W-1:0] fpIdx,
  input wire logic [WIDTH-1:0] fpWrData,
  output logic [WIDTH-1:0] fpRdData
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (fpWrEn) begin
      mem_nxt[fpIdx] = fpWrData;
    end
    // Packed write wins a same-cycle collision
    if (wrEn) begin
      mem_nxt[wrIdx] = wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= psa_pkg::REG_RESET;
      end
      rdDataA <= psa_pkg::REG_RESET;
      rdDataB <= psa_pkg::REG_RESET;
      fpRdData <= psa_pkg::REG_RESET;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
      rdDataA <= mem_r[rdIdxA];
      rdDataB <= mem_r[rdIdxB];
      fpRdData <= mem_r[fpIdx];
    end
  end
endmodule

/* File: testbench/psa_issue_model.sv */
// Issue-side model: decoder feeding the unit one op per cycle
`timescale 1ns/1ps
module psa_issue_model (
  input wire logic core_clk,
  output psa_pkg::psa_issue_s issue
);
  initial begin
    issue = '0;
  end
  task automatic send(input psa_pkg::psa_op_e op, input psa_pkg::psa_size_e sz, input logic [2:0] dst,
                      input logic [2:0] src, input logic ext, input logic [63:0] data);
    @(posedge core_clk);
    #1;
    issue = {1'b1, op, sz, dst, src, ext, data};
  endtask
  // Released data must not keep its last value
  task automatic idle();
    @(posedge core_clk);
    #1;
    issue.valid = 1'b0;
    issue.extData = ~issue.extData;
  endtask
endmodule

/* File: testbench/test_packed_simd_integer_alu.sv */
// Self-checking bench of the packed SIMD integer unit
`timescale 1ns/1ps
module test_packed_simd_integer_alu;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  psa_pkg::psa_issue_s issue;
  psa_pkg::psa_result_s result_r;
  logic [15:0] tagWord_r;
  logic fpWrEn = 1'b0;
  logic [2:0] fpIdx = 3'h0;
  logic [63:0] fpWrData = 64'h0000_0000_0000_0000;
  logic [63:0] fpRdData;
  logic [63:0] got;
  psa_pkg::psa_size_e sz = psa_pkg::SZ_BYTE;
  int fails = 0;
  int checksDone = 0;

  always #4 core_clk = ~core_clk;

  psa_issue_model u_psa_issue_model (.core_clk(core_clk), .issue(issue));
  psa_alu_top u_psa_alu_top (.core_clk(core_clk), .reset(reset), .issue(issue), .result_r(result_r),
    .tagWord_r(tagWord_r), .fpWrEn(fpWrEn), .fpIdx(fpIdx), .fpWrData(fpWrData), .fpRdData(fpRdData));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait for n results; one may already stand on entry, the last is left standing
  task automatic waitRes(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < 10 && seen < n; i++) begin
      if (result_r.valid === 1'b1) begin
        seen++;
        got = result_r.data;
      end
      if (seen < n) begin
        @(posedge core_clk);
        #1;
      end
    end
    if (seen != n) begin
      fails++;
      $display("[ERR] results expected %0d seen %0d", n, seen);
      testDone();
    end
  endtask

  // Load and op back to back, so the op depends on the bypass
  task automatic exec(input psa_pkg::psa_op_e op, input logic [63:0] a, input logic [63:0] b,
                      input logic [63:0] exp);
    u_psa_issue_model.send(psa_pkg::OP_MOV64_IN, sz, 3'h3, 3'h0, 1'b1, a);
    u_psa_issue_model.send(op, sz, 3'h3, 3'h0, 1'b1, b);
    u_psa_issue_model.idle();
    waitRes(2);
    check(op.name(), got, exp);
  endtask

  task automatic testReset();
    check("tag at reset", 64'(tagWord_r), 64'(psa_pkg::TAG_EMPTY));
    check("data at reset", result_r.data, 64'h0000_0000_0000_0000);
    $display("reset done");
  endtask

  task automatic testArith();
    exec(psa_pkg::OP_ADD, 64'h80FF_0102_0304_7F01, 64'h8001_0101_0101_0101, 64'h0000_0203_0405_8002);
    sz = psa_pkg::SZ_DWORD;
    exec(psa_pkg::OP_SUB, 64'h0000_0000_0000_0005, 64'h0000_0001_0000_0006, 64'hFFFF_FFFF_FFFF_FFFF);
    sz = psa_pkg::SZ_BYTE;
    exec(psa_pkg::OP_ADDS, 64'h7F80_0000_0000_0010, 64'h01FF_0000_0000_0005, 64'h7F80_0000_0000_0015);
    exec(psa_pkg::OP_ADDUS, 64'hFF00_0000_0000_00F0, 64'h0101_0000_0000_0020, 64'hFF01_0000_0000_00FF);
    exec(psa_pkg::OP_ADDS, 64'h0000_0000_0080_0070, 64'h0000_0000_00FF_0020, 64'h0000_0000_0080_007F);
    exec(psa_pkg::OP_ADDS, 64'h0000_0000_0070_0080, 64'h0000_0000_0020_00FF, 64'h0000_0000_007F_0080);
    exec(psa_pkg::OP_SUBUS, 64'h0000_0000_0010_0001, 64'h0000_0000_0001_0002, 64'h0000_0000_000F_0000);
    sz = psa_pkg::SZ_WORD;
    exec(psa_pkg::OP_SUBS, 64'h8000_7FFF_0000_0003, 64'h0001_FFFF_0000_0001, 64'h8000_7FFF_0000_0002);
    exec(psa_pkg::OP_SUBUS, 64'h0000_0005_0000_0000, 64'h0001_0002_0000_0000, 64'h0000_0003_0000_0000);
    exec(psa_pkg::OP_MULH, 64'h7FFF_FFFF_0002_8000, 64'h7FFF_FFFF_0003_8000, 64'h3FFF_0000_0000_4000);
    exec(psa_pkg::OP_MULL, 64'h7FFF_FFFF_0002_8000, 64'h7FFF_FFFF_0003_8000, 64'h0001_0001_0006_0000);
    exec(psa_pkg::OP_MADD, 64'h7FFF_FFFF_0002_8000, 64'h7FFF_FFFF_0003_8000, 64'h3FFF_0002_4000_0006);
    $display("arith done");
  endtask

  task automatic testCmpLogic();
    sz = psa_pkg::SZ_BYTE;
    exec(psa_pkg::OP_CMPEQ, 64'h0102_0304_0506_0708, 64'h0100_0304_0000_0708, 64'hFF00_FFFF_0000_FFFF);
    sz = psa_pkg::SZ_WORD;
    exec(psa_pkg::OP_CMPGT, 64'h0001_FFFF_8000_7FFF, 64'h0000_0000_7FFF_8000, 64'hFFFF_0000_0000_FFFF);
    exec(psa_pkg::OP_AND, 64'hF0F0_F0F0_FF00_FF00, 64'hFF00_FF00_F0F0_F0F0, 64'hF000_F000_F000_F000);
    exec(psa_pkg::OP_ANDN, 64'hF0F0_F0F0_FF00_FF00, 64'hFF00_FF00_F0F0_F0F0, 64'h0F00_0F00_00F0_00F0);
    exec(psa_pkg::OP_OR, 64'hF0F0_F0F0_FF00_FF00, 64'hFF00_FF00_F0F0_F0F0, 64'hFFF0_FFF0_FFF0_FFF0);
    exec(psa_pkg::OP_XOR, 64'hF0F0_F0F0_FF00_FF00, 64'hFF00_FF00_F0F0_F0F0, 64'h0FF0_0FF0_0FF0_0FF0);
    $display("compare logic done");
  endtask

  task automatic testConvShift();
    exec(psa_pkg::OP_NARROW_SAT_SIGNED, 64'h0080_FF7F_0012_FFFE, 64'h0000_0001_7FFF_8000, 64'h0001_7F80_7F80_12FE);
    exec(psa_pkg::OP_NARROW_SAT_UNSIGNED, 64'h0100_FFFF_00FF_0080, 64'h0000_0000_0000_0000, 64'h0000_0000_FF00_FF80);
    exec(psa_pkg::OP_UNPH, 64'h0706_0504_0302_0100, 64'h1716_1514_1312_1110, 64'h1716_0706_1514_0504);
    exec(psa_pkg::OP_SLL, 64'h8001_1234_FFFF_000F, 64'h0000_0000_0000_0004, 64'h0010_2340_FFF0_00F0);
    exec(psa_pkg::OP_SRA, 64'h8000_7FFF_F000_0001, 64'h0000_0000_0000_000F, 64'hFFFF_0000_FFFF_0000);
    exec(psa_pkg::OP_SRL, 64'hFFFF_1234_8000_0001, 64'h0000_0000_0000_0010, 64'h0000_0000_0000_0000);
    sz = psa_pkg::SZ_DWORD;
    exec(psa_pkg::OP_NARROW_SAT_SIGNED, 64'h0001_0000_FFFF_0000, 64'h0000_1234_FFFF_FFFE, 64'h1234_FFFE_7FFF_8000);
    exec(psa_pkg::OP_SRA, 64'h8000_0000_7FFF_FFFF, 64'h0000_0000_0000_0028, 64'hFFFF_FFFF_0000_0000);
    sz = psa_pkg::SZ_BYTE;
    exec(psa_pkg::OP_UNPL, 64'h0706_0504_0302_0100, 64'h1716_1514_1312_1110, 64'h1303_1202_1101_1000);
    sz = psa_pkg::SZ_QWORD;
    exec(psa_pkg::OP_SRL, 64'h1122_3344_5566_7788, 64'h0000_0000_0000_0040, 64'h0000_0000_0000_0000);
    $display("convert shift done");
  endtask

  task automatic testMoves();
    u_psa_issue_model.send(psa_pkg::OP_MOV32_IN, sz, 3'h5, 3'h0, 1'b1, 64'hDEAD_BEEF_CAFE_F00D);
    u_psa_issue_model.send(psa_pkg::OP_MOV32_OUT, sz, 3'h5, 3'h0, 1'b0, 64'h0000_0000_0000_0000);
    u_psa_issue_model.idle();
    waitRes(2);
    check("move32 out", got, 64'h0000_0000_CAFE_F00D);
    check("move out flag", 64'(result_r.extValid), 64'h0000_0000_0000_0001);
    check("move out no write", 64'(result_r.dstWritten), 64'h0000_0000_0000_0000);
    u_psa_issue_model.send(psa_pkg::OP_MOV64_IN, sz, 3'h6, 3'h0, 1'b1, 64'h1122_3344_5566_7788);
    u_psa_issue_model.send(psa_pkg::OP_MOV64_RR, sz, 3'h5, 3'h6, 1'b0, 64'h0000_0000_0000_0000);
    u_psa_issue_model.send(psa_pkg::OP_MOV64_OUT, sz, 3'h5, 3'h0, 1'b0, 64'h0000_0000_0000_0000);
    u_psa_issue_model.idle();
    waitRes(2);
    check("move64 out", got, 64'h1122_3344_5566_7788);
    fpIdx = 3'h5;
    fpWrEn = 1'b1;
    fpWrData = 64'hA5A5_0000_5A5A_FFFF;
    @(posedge core_clk);
    #1;
    check("fp view read", fpRdData, 64'h1122_3344_5566_7788);
    fpWrEn = 1'b0;
    u_psa_issue_model.send(psa_pkg::OP_MOV64_OUT, sz, 3'h5, 3'h0, 1'b0, 64'h0000_0000_0000_0000);
    u_psa_issue_model.idle();
    waitRes(1);
    check("fp view write", got, 64'hA5A5_0000_5A5A_FFFF);
    $display("moves done");
  endtask

  task automatic testClear();
    u_psa_issue_model.send(psa_pkg::OP_CLEAR, sz, 3'h0, 3'h0, 1'b0, 64'h0000_0000_0000_0000);
    u_psa_issue_model.idle();
    waitRes(1);
    check("tag after clear", 64'(tagWord_r), 64'(psa_pkg::TAG_EMPTY));
    exec(psa_pkg::OP_OR, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0002, 64'h0000_0000_0000_0003);
    check("tag after op", 64'(tagWord_r), 64'(psa_pkg::TAG_VALID));
    $display("clear done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    testReset();
    testArith();
    testCmpLogic();
    testConvShift();
    testMoves();
    testClear();
    testDone();
  end
endmodule
